/* design/dsw_pkg.sv */
// Constants for the setpoint scaling and watchdog block
// Assumes a 20 MHz system clock and a 32-bit classic Wishbone register bus
package dsw_pkg;
   localparam int          CLK_HZ        = 20_000_000;
   localparam int          MS_PER_S      = 1000;
   localparam int          CYC_PER_MS    = CLK_HZ / MS_PER_S;
   localparam int          WD_MAX_S      = 65;
   localparam logic [31:0] WD_MAX_MS     = 32'(WD_MAX_S * MS_PER_S);
   localparam int          SCALE_SHIFT   = 16;
   localparam int          VEND_SHIFT    = 16;
   localparam int          UCAL_SHIFT    = 20;
   localparam int          LATENCY       = 4;
   // Register byte offsets
   localparam logic [7:0]  A_CTRL        = 8'h00;
   localparam logic [7:0]  A_SCALE_GAIN  = 8'h04;
   localparam logic [7:0]  A_SCALE_OFS   = 8'h08;
   localparam logic [7:0]  A_UCAL_GAIN   = 8'h0c;
   localparam logic [7:0]  A_UCAL_OFS    = 8'h10;
   localparam logic [7:0]  A_VEND_GAIN   = 8'h14;
   localparam logic [7:0]  A_VEND_OFS    = 8'h18;
   localparam logic [7:0]  A_UNLOCK      = 8'h1c;
   localparam logic [7:0]  A_DEFAULT     = 8'h20;
   localparam logic [7:0]  A_RAMP        = 8'h24;
   localparam logic [7:0]  A_WD_MS       = 8'h28;
   localparam logic [7:0]  A_RAW         = 8'h2c;
   localparam logic [7:0]  A_STATUS      = 8'h30;
   // Control field positions
   localparam int          C_SCALE_EN    = 0;
   localparam int          C_VEND_EN     = 1;
   localparam int          C_UCAL_EN     = 2;
   localparam int          C_UNSIGNED    = 3;
   localparam int          C_WD_MODE     = 4;
   // Reset values
   localparam logic [31:0] R_CTRL        = 32'h0000_0000;
   localparam logic [31:0] R_SCALE_GAIN  = 32'h0001_0000;
   localparam logic [31:0] R_UCAL_GAIN   = 32'h0010_0000;
   localparam logic [31:0] R_VEND_GAIN   = 32'h0001_0000;
   localparam logic [31:0] R_ZERO        = 32'h0000_0000;
   localparam logic [31:0] R_WD_MS       = 32'h0000_0064;
   // Unlock key for the vendor pair; the value is arbitrary
   localparam logic [31:0] UNLOCK_KEY    = 32'h5a5a_1234;
   typedef enum logic [1:0] {
      WD_DEFAULT,
      WD_RAMP,
      WD_LAST
   } dsw_wd_mode_t;
endpackage

/* design/dsw_top.sv */
// Setpoint scaling, calibration and process data watchdog for one output
// Assumes setpoints come from logic on clk_i; registers on classic Wishbone
//
// What this block does
// RL1: User scale: gain times setpoint, shift sixteen, offset
// RL2: Disabled user scale passes presented setpoint unchanged
// RL3: Vendor calibration: gain, shift sixteen, add offset
// RL4: User calibration: gain, shift twenty, add offset
// RL5: No calibration forwards scaled value; raw readable
// RL6: Software never enables both calibrations together
// RL7: Vendor gain and offset writable only when unlocked
// RL8: Watchdog forces substitute output when setpoints stop
// RL9: Timeout limited to 65 s, taken modulo
// RL10: Hold output while waiting, reload, resume on data
// RL11: Substitute is default, ramp toward default, or last
// RL12: Unsigned presentation halves incoming setpoint
// RL13: Truncate products, saturate to signed sixteen bits
// RL14: One raw code per setpoint, fixed latency
//
// Local design decisions: the Wishbone register port and the address map.
`timescale 1ns/1ps
module dsw_top #(
   parameter int CYC_PER_MS = dsw_pkg::CYC_PER_MS
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        sp_valid_i,
   input  wire logic [15:0] bus_setpoint_i,
   output logic      [15:0] dac_code_o,
   output logic             dac_valid_o,
   output logic             wd_expired_o
);
   function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[8*b +: 8] = nw[8*b +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic signed [15:0] sat16(input logic signed [48:0] v);
      logic signed [15:0] r;
      r = v[15:0];
      if (v > 49'sd32767) begin
         r = 16'sh7fff;
      end else if (v < -49'sd32768) begin
         r = 16'sh8000;
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Register bus
   logic [31:0] ctrl_q, sgain_q, sofs_q, ugain_q, uofs_q, vgain_q, vofs_q;
   logic [31:0] unlock_q, dflt_q, ramp_q, wdms_q;
   logic        ack_q;
   logic [31:0] dat_q;
   logic signed [15:0] raw_q;
   logic        exp_q;

   wire       req      = wb_cyc_i & wb_stb_i & ~ack_q;
   wire       wr       = req & wb_we_i;
   wire [7:0] a        = {wb_adr_i[7:2], 2'b00};
   wire       unlocked = (unlock_q == dsw_pkg::UNLOCK_KEY);
   wire       vend_wr  = wr & unlocked;                                         // see RL7

   logic [31:0] rd_mux;
   always_comb begin
      unique case (a)
         dsw_pkg::A_CTRL:       rd_mux = ctrl_q;
         dsw_pkg::A_SCALE_GAIN: rd_mux = sgain_q;
         dsw_pkg::A_SCALE_OFS:  rd_mux = sofs_q;
         dsw_pkg::A_UCAL_GAIN:  rd_mux = ugain_q;
         dsw_pkg::A_UCAL_OFS:   rd_mux = uofs_q;
         dsw_pkg::A_VEND_GAIN:  rd_mux = vgain_q;
         dsw_pkg::A_VEND_OFS:   rd_mux = vofs_q;
         dsw_pkg::A_UNLOCK:     rd_mux = {31'h0, unlocked};
         dsw_pkg::A_DEFAULT:    rd_mux = dflt_q;
         dsw_pkg::A_RAMP:       rd_mux = ramp_q;
         dsw_pkg::A_WD_MS:      rd_mux = wdms_q;
         dsw_pkg::A_RAW:        rd_mux = {{16{raw_q[15]}}, raw_q};             // see RL5
         dsw_pkg::A_STATUS:     rd_mux = {31'h0, exp_q};
         default:               rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q    <= 1'b0;
         dat_q    <= dsw_pkg::R_ZERO;
         ctrl_q   <= dsw_pkg::R_CTRL;
         sgain_q  <= dsw_pkg::R_SCALE_GAIN;
         sofs_q   <= dsw_pkg::R_ZERO;
         ugain_q  <= dsw_pkg::R_UCAL_GAIN;
         uofs_q   <= dsw_pkg::R_ZERO;
         vgain_q  <= dsw_pkg::R_VEND_GAIN;
         vofs_q   <= dsw_pkg::R_ZERO;
         unlock_q <= dsw_pkg::R_ZERO;
         dflt_q   <= dsw_pkg::R_ZERO;
         ramp_q   <= dsw_pkg::R_ZERO;
         wdms_q   <= dsw_pkg::R_WD_MS;
      end else begin
         ack_q <= req;
         dat_q <= rd_mux;
         if (wr && a == dsw_pkg::A_CTRL)       ctrl_q   <= wmerge(ctrl_q, wb_dat_i, wb_sel_i);
         if (wr && a == dsw_pkg::A_SCALE_GAIN) sgain_q  <= wmerge(sgain_q, wb_dat_i, wb_sel_i);
         if (wr && a == dsw_pkg::A_SCALE_OFS)  sofs_q   <= wmerge(sofs_q, wb_dat_i, wb_sel_i);
         if (wr && a == dsw_pkg::A_UCAL_GAIN)  ugain_q  <= wmerge(ugain_q, wb_dat_i, wb_sel_i);
         if (wr && a == dsw_pkg::A_UCAL_OFS)   uofs_q   <= wmerge(uofs_q, wb_dat_i, wb_sel_i);
         if (vend_wr && a == dsw_pkg::A_VEND_GAIN) vgain_q <= wmerge(vgain_q, wb_dat_i, wb_sel_i);  // see RL7
         if (vend_wr && a == dsw_pkg::A_VEND_OFS)  vofs_q  <= wmerge(vofs_q, wb_dat_i, wb_sel_i);   // see RL7
         if (wr && a == dsw_pkg::A_UNLOCK)     unlock_q <= wmerge(unlock_q, wb_dat_i, wb_sel_i);
         if (wr && a == dsw_pkg::A_DEFAULT)    dflt_q   <= wmerge(dflt_q, wb_dat_i, wb_sel_i);
         if (wr && a == dsw_pkg::A_RAMP)       ramp_q   <= wmerge(ramp_q, wb_dat_i, wb_sel_i);
         if (wr && a == dsw_pkg::A_WD_MS)      wdms_q   <= wmerge(wdms_q, wb_dat_i, wb_sel_i);
      end
   end
   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;

   ////////////////////////////////////////////////////////////////////////////
   // Conversion pipeline
   logic               v1_q, v2_q, v3_q;
   logic signed [15:0] pres_q, ysc_q;

   wire scale_en = ctrl_q[dsw_pkg::C_SCALE_EN];
   wire vend_en  = ctrl_q[dsw_pkg::C_VEND_EN];
   wire ucal_en  = ctrl_q[dsw_pkg::C_UCAL_EN];
   wire [15:0] pres_d = ctrl_q[dsw_pkg::C_UNSIGNED] ? {1'b0, bus_setpoint_i[15:1]} : bus_setpoint_i;  // see RL12

   wire signed [47:0] sc_prod = pres_q * $signed(sgain_q);
   wire signed [47:0] vd_prod = ysc_q * $signed(vgain_q);
   wire signed [47:0] uc_prod = ysc_q * $signed(ugain_q);
   wire signed [48:0] sc_sum  = 49'(sc_prod >>> dsw_pkg::SCALE_SHIFT) + 49'($signed(sofs_q[15:0]));  // see RL1
   wire signed [48:0] vd_sum  = 49'(vd_prod >>> dsw_pkg::VEND_SHIFT) + 49'($signed(vofs_q[15:0]));   // see RL3
   wire signed [48:0] uc_sum  = 49'(uc_prod >>> dsw_pkg::UCAL_SHIFT) + 49'($signed(uofs_q[15:0]));   // see RL4
   wire signed [15:0] ysc_d   = scale_en ? sat16(sc_sum) : pres_q;             // see RL2 see RL13
   // Vendor wins if software breaks the exclusive enable
   wire signed [15:0] raw_d   = vend_en ? sat16(vd_sum) : (ucal_en ? sat16(uc_sum) : ysc_q);  // see RL5 see RL6

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         v1_q   <= 1'b0;
         v2_q   <= 1'b0;
         v3_q   <= 1'b0;
         pres_q <= 16'sh0000;
         ysc_q  <= 16'sh0000;
         raw_q  <= 16'sh0000;
      end else begin
         v1_q <= sp_valid_i;                                                    // see RL14
         v2_q <= v1_q;
         v3_q <= v2_q;
         if (sp_valid_i) pres_q <= pres_d;
         if (v1_q)       ysc_q  <= ysc_d;
         if (v2_q)       raw_q  <= raw_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Watchdog
   logic [31:0] ms_left_q;
   logic [15:0] tick_cnt_q;
   wire  [31:0] wd_lim  = wdms_q % dsw_pkg::WD_MAX_MS;                           // see RL9
   wire         ms_tick = (tick_cnt_q == 16'(CYC_PER_MS - 1));
   wire         wd_on   = (wd_lim != 32'h0);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tick_cnt_q <= 16'h0000;
         ms_left_q  <= dsw_pkg::R_WD_MS;
         exp_q      <= 1'b0;
      end else begin
         tick_cnt_q <= (ms_tick || sp_valid_i) ? 16'h0000 : tick_cnt_q + 16'h0001;
         if (sp_valid_i) begin
            ms_left_q <= wd_lim;                                                // see RL10
            exp_q     <= 1'b0;
         end else if (wd_on && !exp_q && ms_tick) begin
            ms_left_q <= ms_left_q - 32'h1;
            if (ms_left_q <= 32'h1) exp_q <= 1'b1;                              // see RL8
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output stage
   logic signed [15:0] out_q;
   logic               dv_q;
   logic               exp_d1_q;
   wire dsw_pkg::dsw_wd_mode_t mode = dsw_pkg::dsw_wd_mode_t'(ctrl_q[dsw_pkg::C_WD_MODE +: 2]);
   wire signed [16:0] diff   = 17'($signed(dflt_q[15:0])) - 17'(out_q);
   wire signed [16:0] rate   = {1'b0, ramp_q[15:0]};
   wire signed [16:0] mag    = diff[16] ? -diff : diff;
   wire signed [15:0] step_d = (mag <= rate) ? dflt_q[15:0] : (diff[16] ? 16'(out_q - rate) : 16'(out_q + rate));
   wire               exp_rise = exp_q & ~exp_d1_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         out_q    <= 16'sh0000;
         dv_q     <= 1'b0;
         exp_d1_q <= 1'b0;
      end else begin
         exp_d1_q <= exp_q;
         dv_q     <= 1'b0;
         if (v3_q) begin
            out_q <= raw_q;                                                     // see RL10 see RL14
            dv_q  <= 1'b1;
         end else if (exp_q) begin
            unique case (mode)                                                  // see RL11
               dsw_pkg::WD_DEFAULT: begin
                  out_q <= dflt_q[15:0];
                  dv_q  <= exp_rise;
               end
               dsw_pkg::WD_RAMP: begin
                  if (ms_tick && out_q != dflt_q[15:0]) begin
                     out_q <= step_d;
                     dv_q  <= 1'b1;
                  end
               end
               default: out_q <= out_q;
            endcase
         end
      end
   end
   assign dac_code_o   = out_q;
   assign dac_valid_o  = dv_q;
   assign wd_expired_o = exp_q;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   property p_lat;
      sp_valid_i |-> ##4 (dac_valid_o && dac_code_o == $past(raw_q));
   endproperty
   a_lat: assert property (p_lat) else $error("setpoint not output after four cycles");  // see RL14

   property p_pass;
      v1_q && !scale_en |=> ysc_q == $past(pres_q);
   endproperty
   a_pass: assert property (p_pass) else $error("unscaled setpoint altered");  // see RL2

   property p_half;
      sp_valid_i && ctrl_q[dsw_pkg::C_UNSIGNED] |=> pres_q == 16'($past(bus_setpoint_i) >> 1);
   endproperty
   a_half: assert property (p_half) else $error("unsigned setpoint not halved");  // see RL12

   property p_nocal;
      v2_q && !vend_en && !ucal_en |=> raw_q == $past(ysc_q);
   endproperty
   a_nocal: assert property (p_nocal) else $error("raw code differs from scaled value");  // see RL5

   property p_lock;
      wr && !unlocked && (a == dsw_pkg::A_VEND_GAIN || a == dsw_pkg::A_VEND_OFS)
         |=> $stable(vgain_q) && $stable(vofs_q);
   endproperty
   a_lock: assert property (p_lock) else $error("vendor pair changed while locked");  // see RL7

   property p_lim;
      wd_lim < dsw_pkg::WD_MAX_MS && ms_left_q <= dsw_pkg::WD_MAX_MS;
   endproperty
   a_lim: assert property (p_lim) else $error("watchdog time beyond limit");  // see RL9

   property p_dflt;
      $rose(exp_q) && mode == dsw_pkg::WD_DEFAULT && !v3_q |=> dac_code_o == 16'($past(dflt_q));
   endproperty
   a_dflt: assert property (p_dflt) else $error("default not output on expiry");  // see RL8

   property p_hold;
      !v3_q && !exp_q |=> $stable(dac_code_o);
   endproperty
   a_hold: assert property (p_hold) else $error("output moved without new data");  // see RL10

   property p_sat;
      v2_q && vend_en && vd_sum > 49'sd32767 |=> raw_q == 16'sh7fff;
   endproperty
   a_sat: assert property (p_sat) else $error("raw code not saturated");  // see RL13

   property p_ramp;
      exp_q && mode == dsw_pkg::WD_RAMP && !v3_q && !ms_tick |=> $stable(dac_code_o);
   endproperty
   a_ramp: assert property (p_ramp) else $error("ramp stepped between ticks");  // see RL11
endmodule // dsw_top

/* tb/dsw_sp_src.sv */
// Model of the fieldbus controller that hands setpoints to the block
// Assumes the bench asks for one setpoint per clk_i cycle with go_i high
`timescale 1ns/1ps
module dsw_sp_src (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        go_i,
   input  wire logic [15:0] val_i,
   output logic             sp_valid_o = 1'b0,
   output logic      [15:0] bus_setpoint_o = 16'h0000
);
   // One strobe per request; between strobes the data lines toggle so stale data never looks valid
   always_ff @(posedge clk_i) begin
      sp_valid_o     <= go_i & ~rst_i;
      bus_setpoint_o <= go_i ? val_i : ~bus_setpoint_o;
   end
endmodule // dsw_sp_src

/* tb/dsw_tb_top.sv */
// Self-checking bench for the setpoint scaling and watchdog block
// Assumes the design package is compiled first; ms tick shortened to 10 cycles
`timescale 1ns/1ps
module dsw_tb_top;
   localparam int CPM = 10;
   typedef struct packed {
      logic [31:0] ctrl, sg, so, ug, uo;
      logic [15:0] sp, ex;
   } dsw_row_t;
   logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, go = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [3:0]  sel = 4'hf;
   logic [31:0] wdat = 32'h0, rdat, r;
   logic [15:0] val = 16'h0, sp_d, code;
   logic        sp_v, ack, dv, wexp;
   int          miscompares = 0, n_checks = 0;
   // Control values never set both calibration enables together
   dsw_row_t rows [9] = '{
      '{32'h0, 32'h10000, 32'h0, 32'h100000, 32'h0, 16'h1234, 16'h1234},
      '{32'h1, 32'h8000, 32'hfff0, 32'h100000, 32'h0, 16'h1000, 16'h07f0},
      '{32'h1, 32'h8000, 32'h0, 32'h100000, 32'h0, 16'hffff, 16'hffff},
      '{32'h1, 32'h40000, 32'h0, 32'h100000, 32'h0, 16'h4000, 16'h7fff},
      '{32'h1, 32'h40000, 32'h0, 32'h100000, 32'h0, 16'hc000, 16'h8000},
      '{32'h4, 32'h10000, 32'h0, 32'h200000, 32'h5, 16'h0100, 16'h0205},
      '{32'h4, 32'h10000, 32'h0, 32'h80000, 32'h0, 16'hffff, 16'hffff},
      '{32'h8, 32'h10000, 32'h0, 32'h100000, 32'h0, 16'hfffe, 16'h7fff},
      '{32'h9, 32'h8000, 32'h0, 32'h100000, 32'h0, 16'h8000, 16'h2000}};
   initial begin
      forever #25 clk_i = ~clk_i;
   end
   dsw_sp_src i_dsw_sp_src (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .val_i(val), .sp_valid_o(sp_v),
                            .bus_setpoint_o(sp_d));
   dsw_top #(.CYC_PER_MS(CPM)) i_dsw_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .sp_valid_i(sp_v), .bus_setpoint_i(sp_d), .dac_code_o(code), .dac_valid_o(dv), .wd_expired_o(wexp));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic conclude();
      if (miscompares == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         miscompares++;
         $display("ERROR %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // Classic single Wishbone cycle; holds everything until ack is sampled
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 50);
      r = rdat;
      if (n >= 50) chk(32'hdead, 32'h0);
      cyc <= 1'b0; stb <= 1'b0;
   endtask
   // Sends one setpoint; the valid pulse comes four edges after the strobe leaves the source
   task automatic send(input logic [15:0] v, input logic [15:0] e);
      @(posedge clk_i);
      go <= 1'b1; val <= v;
      @(posedge clk_i);
      go <= 1'b0;
      for (int i = 1; i <= 5; i++) begin
         @(posedge clk_i);
         #1;
         chk(dv, (i == dsw_pkg::LATENCY));
      end
      chk(code, e);
   endtask
   // Lets the watchdog run out and checks timing and substitute value
   task automatic wdog(input logic [1:0] m, input logic [31:0] wd, input int ms);
      int n;
      wb(1'b1, dsw_pkg::A_CTRL, 32'(m) << dsw_pkg::C_WD_MODE);
      wb(1'b1, dsw_pkg::A_WD_MS, wd);
      send(16'h0100, 16'h0100);
      n = 0;
      while (wexp !== 1'b1 && n < 2000) begin
         @(posedge clk_i);
         #1;
         n++;
         if (wexp !== 1'b1 && dv !== 1'b0) chk(dv, 1'b0);
      end
      chk(n >= (ms - 1) * CPM && n <= (ms + 1) * CPM + 8, 1'b1);
      @(posedge clk_i);
      #1;
      chk(dv, m == 2'd0);
      repeat (3 * CPM) @(posedge clk_i);
      #1;
      if (m == 2'd1) chk(code != 16'h0100 && code != 16'h0055, 1'b1);
      else chk(code, (m == 2'd0) ? 16'h0055 : 16'h0100);
      repeat (30 * CPM) @(posedge clk_i);
      chk(code, (m == 2'd2) ? 16'h0100 : 16'h0055);
      wb(1'b0, dsw_pkg::A_STATUS, 32'h0);
      chk(r, 32'h1);
      send(16'h0200, 16'h0200);
      chk(wexp, 1'b0);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      foreach (rows[k]) begin
         wb(1'b1, dsw_pkg::A_CTRL, rows[k].ctrl);
         wb(1'b1, dsw_pkg::A_SCALE_GAIN, rows[k].sg);
         wb(1'b1, dsw_pkg::A_SCALE_OFS, rows[k].so);
         wb(1'b1, dsw_pkg::A_UCAL_GAIN, rows[k].ug);
         wb(1'b1, dsw_pkg::A_UCAL_OFS, rows[k].uo);
         send(rows[k].sp, rows[k].ex);
         wb(1'b0, dsw_pkg::A_RAW, 32'h0);
         chk(r[15:0], rows[k].ex);
      end
      // Vendor pair stays locked until the key is written
      wb(1'b1, dsw_pkg::A_CTRL, 32'h2);
      wb(1'b1, dsw_pkg::A_VEND_OFS, 32'h7);
      wb(1'b1, dsw_pkg::A_VEND_GAIN, 32'h30000);
      send(16'h0100, 16'h0100);
      wb(1'b1, dsw_pkg::A_UNLOCK, dsw_pkg::UNLOCK_KEY);
      wb(1'b0, dsw_pkg::A_UNLOCK, 32'h0);
      chk(r, 32'h1);
      wb(1'b1, dsw_pkg::A_VEND_GAIN, 32'h20000);
      wb(1'b1, dsw_pkg::A_VEND_OFS, 32'h3);
      send(16'h0100, 16'h0203);
      send(16'h7000, 16'h7fff);
      wb(1'b1, dsw_pkg::A_DEFAULT, 32'h55);
      wb(1'b1, dsw_pkg::A_RAMP, 32'h10);
      wdog(2'd0, 32'd3, 3);
      wdog(2'd1, 32'd65002, 2);
      wdog(2'd2, 32'd4, 4);
      // Second reset mid-run restores the register defaults
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      #1;
      chk({code, 15'h0, wexp}, 32'h0);
      wb(1'b1, dsw_pkg::A_RAW, 32'h1234);
      wb(1'b0, dsw_pkg::A_RAW, 32'h0);
      chk(r, 32'h0);
      wb(1'b0, dsw_pkg::A_SCALE_GAIN, 32'h0);
      chk(r, dsw_pkg::R_SCALE_GAIN);
      wb(1'b0, dsw_pkg::A_UCAL_GAIN, 32'h0);
      chk(r, dsw_pkg::R_UCAL_GAIN);
      wb(1'b0, dsw_pkg::A_WD_MS, 32'h0);
      chk(r, dsw_pkg::R_WD_MS);
      wb(1'b0, 8'hfc, 32'h0);
      chk(r, 32'h0);
      // Back-to-back setpoints leave with the same spacing
      @(posedge clk_i);
      go <= 1'b1; val <= 16'h0011;
      @(posedge clk_i);
      val <= 16'h0022;
      @(posedge clk_i);
      go <= 1'b0;
      repeat (3) @(posedge clk_i);
      #1;
      chk({dv, code}, {1'b1, 16'h0011});
      @(posedge clk_i);
      #1;
      chk({dv, code}, {1'b1, 16'h0022});
      conclude();
   end
   initial begin
      repeat (20000) @(posedge clk_i);
      miscompares++;
      conclude();
   end
endmodule // dsw_tb_top
